// file: rtl/pif_ctrl.sv
// Purpose: Peripheral interrupt request flags, enables and CPU request gating
// Assumes: Software port with read data one cycle after the read strobe
// Notes: Set wins over a software clear in the same cycle
`default_nettype none
module pif_ctrl
    import pif_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    pif_link_if.dev link,
    input wire logic [PIF_AW-1:0] sw_addr,
    input wire logic [PIF_DW-1:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [PIF_DW-1:0] sw_rdata,
    output logic [PIF_DW-1:0] serial_tx_data_reg,
    input wire logic [PIF_DW-1:0] serial_rx_data_reg
);
    logic [7:0] irq_control_reg_ff;
    logic [7:0] periph_enable_reg_one_ff;
    logic capcmp_two_irq_enable_ff;
    logic [7:0] req_ff;
    logic capcmp_two_flag_ff;
    logic [7:0] sw_rdata_ff;
    logic [7:0] tx_data_ff;
    logic [7:0] nxt_req;
    logic nxt_cc2;

    wire wr_ctrl = sw_wr && (sw_addr == PIF_ADDR_CTRL);
    wire wr_en1 = sw_wr && (sw_addr == PIF_ADDR_EN1);
    wire wr_en2 = sw_wr && (sw_addr == PIF_ADDR_EN2);
    wire wr_req1 = sw_wr && (sw_addr == PIF_ADDR_REQ1);
    wire wr_req2 = sw_wr && (sw_addr == PIF_ADDR_REQ2);
    wire wr_tx = sw_wr && (sw_addr == PIF_ADDR_TXDATA);
    wire rd_rx = sw_rd && (sw_addr == PIF_ADDR_RXDATA);

    function automatic logic cc_event(input pif_cc_mode_t mode, input logic cap,
                                      input logic match);
        unique case (mode)
            PIF_CC_CAPTURE: cc_event = cap;
            PIF_CC_COMPARE: cc_event = match;
            PIF_CC_PWM: cc_event = 1'b0;
            PIF_CC_OFF: cc_event = 1'b0;
        endcase
    endfunction : cc_event

    wire cc1_evt = cc_event(link.cc1_mode, link.cc1_capture, link.cc1_match);
    wire cc2_evt = cc_event(link.cc2_mode, link.cc2_capture, link.cc2_match);

    wire [7:0] set_vec = {1'b0, link.adc_done, 2'b00, link.ssp_done, cc1_evt,
                          link.t2_match, link.t1_overflow};

    always_comb begin
        nxt_req = req_ff;
        if (wr_req1) begin
            nxt_req = (req_ff & ~PIF_REQ1_WMASK) | (sw_wdata & PIF_REQ1_WMASK);
        end
        nxt_req = nxt_req | set_vec;
        nxt_cc2 = wr_req2 ? sw_wdata[PIF_BIT_CC2] : capcmp_two_flag_ff;
        nxt_cc2 = nxt_cc2 | cc2_evt;
    end

    wire [7:0] req_view = {~link.t1_gate_active, req_ff[PIF_BIT_ADC], link.rx_full,
                           link.tx_empty, req_ff[PIF_BIT_SSP:PIF_BIT_T1OV]};

    wire [7:0] en2_view = {7'h00, capcmp_two_irq_enable_ff};

    wire [7:0] rd_mux = (sw_addr == PIF_ADDR_CTRL) ? irq_control_reg_ff :
                        (sw_addr == PIF_ADDR_EN1) ? periph_enable_reg_one_ff :
                        (sw_addr == PIF_ADDR_EN2) ? en2_view :
                        (sw_addr == PIF_ADDR_REQ1) ? req_view :
                        (sw_addr == PIF_ADDR_REQ2) ? {7'h00, capcmp_two_flag_ff} :
                        (sw_addr == PIF_ADDR_RXDATA) ? serial_rx_data_reg :
                        (sw_addr == PIF_ADDR_TXDATA) ? tx_data_ff : PIF_BYTE_RST;

    wire cc2_pend = capcmp_two_flag_ff & capcmp_two_irq_enable_ff;
    wire periph_pend = (|(req_view & periph_enable_reg_one_ff)) | cc2_pend;

    wire irq_level = irq_control_reg_ff[PIF_BIT_GIE] & irq_control_reg_ff[PIF_BIT_PIE]
                     & periph_pend;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_control_reg_ff <= PIF_BYTE_RST;
            periph_enable_reg_one_ff <= PIF_BYTE_RST;
            capcmp_two_irq_enable_ff <= 1'b0;
            req_ff <= PIF_BYTE_RST;
            capcmp_two_flag_ff <= 1'b0;
            tx_data_ff <= PIF_BYTE_RST;
            sw_rdata_ff <= PIF_BYTE_RST;
        end else begin
            if (wr_ctrl) begin
                irq_control_reg_ff <= sw_wdata;
            end
            if (wr_en1) begin
                periph_enable_reg_one_ff <= sw_wdata;
            end
            if (wr_en2) begin
                capcmp_two_irq_enable_ff <= |(sw_wdata & PIF_EN2_MASK);
            end
            if (wr_tx) begin
                tx_data_ff <= sw_wdata;
            end
            req_ff <= nxt_req;
            capcmp_two_flag_ff <= nxt_cc2;
            sw_rdata_ff <= sw_rd ? rd_mux : PIF_BYTE_RST;
        end
    end

    assign sw_rdata = sw_rdata_ff;
    assign serial_tx_data_reg = tx_data_ff;
    assign link.rx_data_read = rd_rx;
    assign link.tx_data_write = wr_tx;
    assign link.cpu_irq = irq_level;
endmodule : pif_ctrl
`default_nettype wire

// file: rtl/pif_pkg.sv
// Purpose: Shared constants for the peripheral interrupt flag and enable logic
// Assumes: One clock, asynchronous active-low reset
// Notes: Register indices are local choices
`default_nettype none
package pif_pkg;
    localparam int PIF_AW = 3;
    localparam int PIF_DW = 8;
    // Register addresses on the software port
    localparam logic [2:0] PIF_ADDR_CTRL = 3'h0;
    localparam logic [2:0] PIF_ADDR_EN1 = 3'h1;
    localparam logic [2:0] PIF_ADDR_EN2 = 3'h2;
    localparam logic [2:0] PIF_ADDR_REQ1 = 3'h3;
    localparam logic [2:0] PIF_ADDR_REQ2 = 3'h4;
    localparam logic [2:0] PIF_ADDR_RXDATA = 3'h5;
    localparam logic [2:0] PIF_ADDR_TXDATA = 3'h6;
    // Bit positions
    localparam int PIF_BIT_GIE = 7;
    localparam int PIF_BIT_PIE = 6;
    localparam int PIF_BIT_T1G = 7;
    localparam int PIF_BIT_ADC = 6;
    localparam int PIF_BIT_RX = 5;
    localparam int PIF_BIT_TX = 4;
    localparam int PIF_BIT_SSP = 3;
    localparam int PIF_BIT_CC1 = 2;
    localparam int PIF_BIT_T2 = 1;
    localparam int PIF_BIT_T1OV = 0;
    localparam int PIF_BIT_CC2 = 0;
    // Writable masks: rx and tx flags are read-only, gate flag follows the inverted gate
    localparam logic [7:0] PIF_REQ1_WMASK = 8'h4F;
    localparam logic [7:0] PIF_BYTE_RST = 8'h00;
    localparam logic [7:0] PIF_EN2_MASK = 8'h01;
    // Capture/compare modes
    typedef enum logic [1:0] {
        PIF_CC_CAPTURE,
        PIF_CC_COMPARE,
        PIF_CC_PWM,
        PIF_CC_OFF
    } pif_cc_mode_t;
endpackage : pif_pkg
`default_nettype wire

// file: rtl/pif_link_if.sv
// Purpose: Joins peripheral event sources to the interrupt flag logic
// Assumes: Single clock domain, all signals synchronous
// Notes: Events are one-cycle pulses, levels are levels
`default_nettype none
interface pif_link_if;
    import pif_pkg::*;
    logic t1_gate_active;
    logic adc_done;
    logic rx_full;
    logic tx_empty;
    logic ssp_done;
    logic cc1_capture;
    logic cc1_match;
    pif_cc_mode_t cc1_mode;
    logic cc2_capture;
    logic cc2_match;
    pif_cc_mode_t cc2_mode;
    logic t2_match;
    logic t1_overflow;
    logic rx_data_read;
    logic tx_data_write;
    logic cpu_irq;
    modport dev (
        input t1_gate_active, adc_done, rx_full, tx_empty, ssp_done,
        input cc1_capture, cc1_match, cc1_mode, cc2_capture, cc2_match, cc2_mode,
        input t2_match, t1_overflow,
        output rx_data_read, tx_data_write, cpu_irq
    );
    modport per (
        output t1_gate_active, adc_done, rx_full, tx_empty, ssp_done,
        output cc1_capture, cc1_match, cc1_mode, cc2_capture, cc2_match, cc2_mode,
        output t2_match, t1_overflow,
        input rx_data_read, tx_data_write, cpu_irq
    );
endinterface : pif_link_if
`default_nettype wire

// file: rtl/pif_periph.sv
// Purpose: Peripheral end that drives events and buffer states onto the link
// Assumes: User side supplies one-cycle event pulses on the same clock
// Notes: Rx full and tx empty are held here and cleared by the link strobes
`default_nettype none
module pif_periph
    import pif_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    pif_link_if.per link,
    input wire logic usr_gate_active,
    input wire logic usr_adc_done,
    input wire logic usr_rx_byte,
    input wire logic usr_tx_sent,
    input wire logic usr_ssp_done,
    input wire logic usr_cc1_capture,
    input wire logic usr_cc1_match,
    input wire pif_cc_mode_t usr_cc1_mode,
    input wire logic usr_cc2_capture,
    input wire logic usr_cc2_match,
    input wire pif_cc_mode_t usr_cc2_mode,
    input wire logic usr_t2_match,
    input wire logic usr_t1_overflow,
    output logic cpu_irq
);
    logic rx_full_ff;
    logic tx_empty_ff;

    wire nxt_rx_full = usr_rx_byte | (rx_full_ff & ~link.rx_data_read);
    wire nxt_tx_empty = usr_tx_sent | (tx_empty_ff & ~link.tx_data_write);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_full_ff <= 1'b0;
            tx_empty_ff <= 1'b1;
        end else begin
            rx_full_ff <= nxt_rx_full;
            tx_empty_ff <= nxt_tx_empty;
        end
    end

    assign link.t1_gate_active = usr_gate_active;
    assign link.adc_done = usr_adc_done;
    assign link.rx_full = rx_full_ff;
    assign link.tx_empty = tx_empty_ff;
    assign link.ssp_done = usr_ssp_done;
    assign link.cc1_capture = usr_cc1_capture;
    assign link.cc1_match = usr_cc1_match;
    assign link.cc1_mode = usr_cc1_mode;
    assign link.cc2_capture = usr_cc2_capture;
    assign link.cc2_match = usr_cc2_match;
    assign link.cc2_mode = usr_cc2_mode;
    assign link.t2_match = usr_t2_match;
    assign link.t1_overflow = usr_t1_overflow;
    assign cpu_irq = link.cpu_irq;
endmodule : pif_periph
`default_nettype wire

// file: bench/pif_link_checker.sv
// Purpose: Concurrent checks on the link between flag logic and peripheral end
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Sees only link signals
`default_nettype none
module pif_link_checker (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic rx_full,
    input wire logic tx_empty,
    input wire logic rx_data_read,
    input wire logic tx_data_write,
    input wire logic cpu_irq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence s_rx_taken;
        rx_full && rx_data_read;
    endsequence
    sequence s_tx_taken;
        tx_empty && tx_data_write;
    endsequence
    chk_reset_state: assert property ($rose(arst_n) |-> tx_empty && !rx_full && !cpu_irq)
        else $error("link not idle after reset");
    chk_rx_clear: assert property (s_rx_taken |=> !rx_full)
        else $error("rx full kept after data read");
    chk_tx_clear: assert property (s_tx_taken |=> !tx_empty)
        else $error("tx empty kept after data write");
    chk_rx_fall: assert property ($fell(rx_full) |-> $past(rx_data_read))
        else $error("rx full dropped without read");
    chk_tx_fall: assert property ($fell(tx_empty) |-> $past(tx_data_write))
        else $error("tx empty dropped without write");
    chk_rx_arrive: assert property ($rose(rx_full) |-> !$past(rx_data_read))
        else $error("rx full rose on a read");
    chk_tx_refill: assert property ($rose(tx_empty) |-> !$past(tx_data_write))
        else $error("tx empty rose on a write");
    chk_strobe_excl: assert property (!(rx_data_read && tx_data_write))
        else $error("rx read and tx write together");
endmodule : pif_link_checker
`default_nettype wire

// file: bench/tb.sv
// Purpose: Self-checking bench for both ends of the interrupt flag link
// Assumes: 200 MHz clock, reset held 16 cycles
// Notes: Event pulses are bits of one vector
`default_nettype none
module tb import pif_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [2:0] sw_addr = '0;
    logic [7:0] sw_wdata = '0;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic [7:0] sw_rdata;
    logic [7:0] tx_reg;
    logic [7:0] rx_reg = 8'hA5;
    logic gate = 1'b0;
    logic irq;
    logic [9:0] ev = '0;
    pif_cc_mode_t cc1_mode = PIF_CC_CAPTURE;
    pif_cc_mode_t cc2_mode = PIF_CC_CAPTURE;
    int n_errors = 0;
    int compares = 0;
    pif_link_if link ();
    pif_ctrl i_pif_ctrl (.core_clk(core_clk), .arst_n(arst_n), .link(link), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
        .serial_tx_data_reg(tx_reg), .serial_rx_data_reg(rx_reg));
    pif_periph i_pif_periph (.core_clk(core_clk), .arst_n(arst_n), .link(link),
        .usr_gate_active(gate), .usr_adc_done(ev[0]), .usr_rx_byte(ev[8]), .usr_tx_sent(ev[9]),
        .usr_ssp_done(ev[1]), .usr_cc1_capture(ev[4]), .usr_cc1_match(ev[5]),
        .usr_cc1_mode(cc1_mode), .usr_cc2_capture(ev[6]), .usr_cc2_match(ev[7]),
        .usr_cc2_mode(cc2_mode), .usr_t2_match(ev[2]), .usr_t1_overflow(ev[3]), .cpu_irq(irq));
    pif_link_checker i_pif_link_checker (.core_clk(core_clk), .arst_n(arst_n),
        .rx_full(link.rx_full), .tx_empty(link.tx_empty), .rx_data_read(link.rx_data_read),
        .tx_data_write(link.tx_data_write), .cpu_irq(link.cpu_irq));
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge core_clk);
        sw_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge core_clk);
        sw_rd <= 1'b0;
        #1 check(sw_rdata, exp);
    endtask : rd
    task automatic irq_is(input logic e);
        #1 check({7'h00, irq}, {7'h00, e});
    endtask : irq_is
    task automatic fire(input int i);
        @(posedge core_clk);
        ev <= 10'h001 << i;
        @(posedge core_clk);
        ev <= '0;
    endtask : fire
    task automatic print_verdict();
        $display("compares %0d, errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #20000;
        n_errors++;
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(PIF_ADDR_REQ1, 8'h90);
        rd(PIF_ADDR_EN2, 8'h00);
        wr(PIF_ADDR_EN2, 8'hFF);
        rd(PIF_ADDR_EN2, 8'h01);
        rd(3'h7, 8'h00);
        $display("test reset view done");
        for (int i = 0; i < 5; i++) begin
            fire(i);
        end
        rd(PIF_ADDR_REQ1, 8'hDF);
        irq_is(1'b0);
        wr(PIF_ADDR_REQ1, 8'h00);
        rd(PIF_ADDR_REQ1, 8'h90);
        fire(1);
        rd(PIF_ADDR_REQ1, 8'h98);
        fire(2);
        rd(PIF_ADDR_REQ1, 8'h9A);
        fork
            fire(3);
            wr(PIF_ADDR_REQ1, 8'h00);
        join
        rd(PIF_ADDR_REQ1, 8'h91);
        wr(PIF_ADDR_REQ1, 8'h00);
        $display("test sticky flags done");
        wr(PIF_ADDR_EN1, 8'h40);
        fire(0);
        wr(PIF_ADDR_CTRL, 8'h40);
        irq_is(1'b0);
        wr(PIF_ADDR_CTRL, 8'h80);
        irq_is(1'b0);
        wr(PIF_ADDR_CTRL, 8'hC0);
        irq_is(1'b1);
        wr(PIF_ADDR_REQ1, 8'h00);
        irq_is(1'b0);
        wr(PIF_ADDR_EN1, 8'h00);
        fire(6);
        irq_is(1'b1);
        rd(PIF_ADDR_REQ2, 8'h01);
        wr(PIF_ADDR_EN2, 8'h00);
        irq_is(1'b0);
        $display("test gating done");
        @(posedge core_clk);
        cc1_mode <= PIF_CC_COMPARE;
        fire(4);
        rd(PIF_ADDR_REQ1, 8'h90);
        fire(5);
        rd(PIF_ADDR_REQ1, 8'h94);
        wr(PIF_ADDR_REQ1, 8'h00);
        cc1_mode <= PIF_CC_PWM;
        gate <= 1'b1;
        fire(5);
        cc1_mode <= PIF_CC_OFF;
        fire(4);
        rd(PIF_ADDR_REQ1, 8'h10);
        @(posedge core_clk);
        gate <= 1'b0;
        cc2_mode <= PIF_CC_OFF;
        wr(PIF_ADDR_REQ2, 8'h00);
        fire(6);
        fire(7);
        rd(PIF_ADDR_REQ2, 8'h00);
        cc2_mode <= PIF_CC_COMPARE;
        fire(7);
        rd(PIF_ADDR_REQ2, 8'h01);
        $display("test capture compare done");
        fire(8);
        rd(PIF_ADDR_REQ1, 8'hB0);
        rd(PIF_ADDR_RXDATA, 8'hA5);
        rd(PIF_ADDR_REQ1, 8'h90);
        wr(PIF_ADDR_TXDATA, 8'h3C);
        #1 check(tx_reg, 8'h3C);
        rd(PIF_ADDR_REQ1, 8'h80);
        fire(9);
        rd(PIF_ADDR_REQ1, 8'h90);
        $display("test serial buffers done");
        print_verdict();
    end
endmodule : tb
`default_nettype wire
